// ===== shared/fifo_ofs_pkg.sv
// Constants, types and bus carriers for the FIFO offset access and retransmit block.
// Assumes a single 100 MHz clock; the write and read ports are both sampled on it.
package fifo_ofs_pkg;

  localparam int DATA_W = 72;
  localparam int ADDR_W = 6;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PART_W = 16;
  localparam int OFS_W = 2 * PART_W;
  localparam int WB_AW = 4;
  localparam int WB_DW = 32;

  // Register byte offsets
  localparam logic [WB_AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [WB_AW-1:0] OFS_STATUS = 4'h4;
  localparam logic [WB_AW-1:0] OFS_EMPTY_OFS = 4'h8;
  localparam logic [WB_AW-1:0] OFS_FULL_OFS = 4'hC;

  // Control fields
  localparam int CTRL_FLAG_EN_BIT = 0;
  localparam int CTRL_SOFT_PRS_BIT = 1;
  localparam logic CTRL_FLAG_EN_RST = 1'b1;

  // Status fields
  localparam int ST_LOADSEQ_LSB = 0;
  localparam int ST_READSEQ_BIT = 2;
  localparam int ST_RTSTATE_LSB = 3;
  localparam int ST_EVALID_BIT = 6;
  localparam int ST_FVALID_BIT = 7;
  localparam int ST_FALL_THROUGH_MODE_BIT = 8;
  localparam int ST_SERIAL_BIT = 9;
  localparam int ST_COUNT_LSB = 16;

  // Offset register reset values
  localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 32'h0000_0007;
  localparam logic [OFS_W-1:0] FULL_OFS_RST = 32'h0000_0007;

  // Offset load sequence positions
  localparam logic [1:0] SEQ_EMPTY_LO = 2'h0;
  localparam logic [1:0] SEQ_EMPTY_HI = 2'h1;
  localparam logic [1:0] SEQ_FULL_LO = 2'h2;
  localparam logic [1:0] SEQ_FULL_HI = 2'h3;

  // Offset read sequence positions: each read returns one whole offset
  localparam logic RSEQ_EMPTY = 1'b0;
  localparam logic RSEQ_FULL = 1'b1;

  typedef enum logic [2:0] {
    RT_NORMAL = 3'b001,
    RT_MARKED = 3'b010,
    RT_SETUP = 3'b100
  } rtState_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_AW-1:0] adr;
    logic [3:0] sel;
    logic [WB_DW-1:0] dat;
  } wbReq_t;

  typedef struct packed {
    logic ack;
    logic [WB_DW-1:0] dat;
  } wbRsp_t;

endpackage : fifo_ofs_pkg

// ===== src/fifo_offset_retransmit.sv
// FIFO core with parallel offset load/read sequencing and retransmit from mark.
// Assumes write and read ports synchronous to mclk and a classic Wishbone master.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module fifo_offset_retransmit (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire fifo_ofs_pkg::wbReq_t wbIn,
  output fifo_ofs_pkg::wbRsp_t wbOut,
  // Device resets and straps
  input wire logic masterReset,
  input wire logic partialReset,
  input wire logic fallThroughStrap,
  input wire logic serialProgStrap,
  // Write port
  input wire logic writeEnable_n,
  input wire logic offsetAccessSelect_n,
  input wire logic [fifo_ofs_pkg::DATA_W-1:0] inputBus,
  // Read port
  input wire logic readEnable_n,
  input wire logic mark,
  input wire logic rewindRequest_n,
  output logic [fifo_ofs_pkg::DATA_W-1:0] outputBus,
  // Flags
  output logic emptyFlag_n,
  output logic almostEmptyFlag,
  output logic almostFullFlag
);

  localparam int AW = fifo_ofs_pkg::ADDR_W;
  localparam int OW = fifo_ofs_pkg::OFS_W;
  localparam int PW = fifo_ofs_pkg::PART_W;
  localparam logic [OW:0] DEPTH_EXT = (OW+1)'(fifo_ofs_pkg::DEPTH);

  logic [fifo_ofs_pkg::DATA_W-1:0] mem [fifo_ofs_pkg::DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic [AW:0] markAddr_r;
  logic [AW:0] wpNxt;
  logic [AW:0] rpNxt;
  logic [OW-1:0] emptyOfs_r;
  logic [OW-1:0] fullOfs_r;
  logic [1:0] loadSeq_r;
  logic rdSeq_r;
  logic fallThroughMode_r;
  logic serialMode_r;
  logic eDone_r;
  logic fDone_r;
  logic eValid_r;
  logic fValid_r;
  logic outValid_r;
  logic outValidNxt;
  logic flagsEnable_r;
  logic softPrs_r;
  fifo_ofs_pkg::rtState_t rtState_r;
  fifo_ofs_pkg::rtState_t rtStateNxt;

  // Resets: master clears all but the control register, partial keeps offsets, sequences and mode
  wire hardRst = sys_rst | masterReset;
  wire softRst = partialReset | softPrs_r;

  wire [AW:0] count = wp_r - rp_r;
  wire fifoEmpty = (count == '0);
  wire fifoFull = count[AW];

  // Port decode
  wire wrOffset = !writeEnable_n && !offsetAccessSelect_n && !serialMode_r;
  wire rdOffset = !readEnable_n && !offsetAccessSelect_n;
  wire rtNormal = (rtState_r == fifo_ofs_pkg::RT_NORMAL);
  wire inSetup = (rtState_r == fifo_ofs_pkg::RT_SETUP);
  wire setupHold = inSetup && !rewindRequest_n;
  wire markBlock = !rtNormal && (wp_r[AW-1:0] == markAddr_r[AW-1:0]);
  wire wrMem = !writeEnable_n && offsetAccessSelect_n && !fifoFull && !markBlock;
  wire rdStd = !fallThroughMode_r && !readEnable_n && offsetAccessSelect_n && !fifoEmpty
               && !inSetup;
  wire fwftLoad = fallThroughMode_r && offsetAccessSelect_n && !setupHold && !fifoEmpty
                  && (!outValid_r || !readEnable_n);
  wire fwftDrain = fallThroughMode_r && offsetAccessSelect_n && !readEnable_n && !fwftLoad
                   && !setupHold;
  wire rdMem = rdStd || fwftLoad;

  // Mark is taken while the output register holds a real word (fall-through) or while the FIFO is not empty (standard)
  wire markReady = fallThroughMode_r ? !emptyFlag_n : emptyFlag_n;
  wire markEnter = rtNormal && mark && markReady;

  // Retransmit state
  always_comb
  begin
    rtStateNxt = rtState_r;
    unique case (rtState_r)
      fifo_ofs_pkg::RT_NORMAL:
      begin
        if (markEnter)
          rtStateNxt = fifo_ofs_pkg::RT_MARKED;
      end
      fifo_ofs_pkg::RT_MARKED:
      begin
        if (!mark)
          rtStateNxt = fifo_ofs_pkg::RT_NORMAL;
        else if (!rewindRequest_n)
          rtStateNxt = fifo_ofs_pkg::RT_SETUP;
      end
      fifo_ofs_pkg::RT_SETUP:
      begin
        if (!mark)
          rtStateNxt = fifo_ofs_pkg::RT_NORMAL;
        else if (rewindRequest_n)
          rtStateNxt = fifo_ofs_pkg::RT_MARKED;
      end
      default:
        rtStateNxt = fifo_ofs_pkg::RT_NORMAL;
    endcase
  end

  // Pointer next values; a rewind overrides any read in the same edge
  wire rewindNow = mark && !rewindRequest_n && (rtState_r != fifo_ofs_pkg::RT_NORMAL);
  assign wpNxt = wrMem ? wp_r + (AW+1)'(1) : wp_r;
  assign rpNxt = rewindNow ? markAddr_r : (rdMem ? rp_r + (AW+1)'(1) : rp_r);
  wire [AW:0] countNxt = wpNxt - rpNxt;

  always_comb
  begin
    outValidNxt = outValid_r;
    if (rewindNow)
      outValidNxt = 1'b0;
    else if (fwftLoad)
      outValidNxt = 1'b1;
    else if (fwftDrain)
      outValidNxt = 1'b0;
  end

  // Standard: empty flag low while empty or in rewind setup; fall-through: output-valid
  wire emptyFlagNxt = fallThroughMode_r ? !outValidNxt
                      : ((countNxt != '0) && (rtStateNxt != fifo_ofs_pkg::RT_SETUP));

  always_ff @(posedge mclk)
  begin
    if (wrMem)
      mem[wp_r[AW-1:0]] <= inputBus;
  end

  always_ff @(posedge mclk)
  begin
    if (hardRst || softRst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      markAddr_r <= '0;
      rtState_r <= fifo_ofs_pkg::RT_NORMAL;
      outValid_r <= 1'b0;
      emptyFlag_n <= fallThroughMode_r && !hardRst;
    end
    else
    begin
      wp_r <= wpNxt;
      rp_r <= rpNxt;
      rtState_r <= rtStateNxt;
      outValid_r <= outValidNxt;
      emptyFlag_n <= emptyFlagNxt;
      if (markEnter)
        markAddr_r <= rp_r - (AW+1)'(1);
    end
  end

  // Output register: offset reads overwrite whatever word was there
  wire [OW-1:0] offsetWord = (rdSeq_r == fifo_ofs_pkg::RSEQ_FULL) ? fullOfs_r : emptyOfs_r;
  always_ff @(posedge mclk)
  begin
    if (hardRst || softRst)
      outputBus <= '0;
    else if (rdOffset)
      outputBus <= {{(fifo_ofs_pkg::DATA_W-OW){1'b0}}, offsetWord};
    else if (rdMem)
      outputBus <= mem[rp_r[AW-1:0]];
  end

  // Mode straps are captured only while sys_rst or master reset is applied
  always_ff @(posedge mclk)
  begin
    if (hardRst)
    begin
      fallThroughMode_r <= fallThroughStrap;
      serialMode_r <= serialProgStrap;
    end
  end

  // Offset load and read sequencing; partial reset does not touch them
  always_ff @(posedge mclk)
  begin
    if (hardRst)
    begin
      loadSeq_r <= fifo_ofs_pkg::SEQ_EMPTY_LO;
      rdSeq_r <= fifo_ofs_pkg::RSEQ_EMPTY;
      emptyOfs_r <= fifo_ofs_pkg::EMPTY_OFS_RST;
      fullOfs_r <= fifo_ofs_pkg::FULL_OFS_RST;
    end
    else
    begin
      if (wrOffset)
      begin
        loadSeq_r <= loadSeq_r + 2'h1;
        unique case (loadSeq_r)
          fifo_ofs_pkg::SEQ_EMPTY_LO: emptyOfs_r[PW-1:0] <= inputBus[PW-1:0];
          fifo_ofs_pkg::SEQ_EMPTY_HI: emptyOfs_r[OW-1:PW] <= inputBus[PW-1:0];
          fifo_ofs_pkg::SEQ_FULL_LO: fullOfs_r[PW-1:0] <= inputBus[PW-1:0];
          fifo_ofs_pkg::SEQ_FULL_HI: fullOfs_r[OW-1:PW] <= inputBus[PW-1:0];
        endcase
      end
      if (rdOffset)
        rdSeq_r <= !rdSeq_r;
    end
  end

  // Flag validity: cleared when a flag's offset starts loading, set when it completes
  always_ff @(posedge mclk)
  begin
    if (hardRst)
    begin
      eDone_r <= 1'b1;
      fDone_r <= 1'b1;
      eValid_r <= 1'b1;
      fValid_r <= 1'b1;
    end
    else
    begin
      if (wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_EMPTY_LO)
        eDone_r <= 1'b0;
      else if (wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_EMPTY_HI)
        eDone_r <= 1'b1;
      if (wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_FULL_LO)
        fDone_r <= 1'b0;
      else if (wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_FULL_HI)
        fDone_r <= 1'b1;
      eValid_r <= eDone_r;
      fValid_r <= fDone_r;
    end
  end

  // Almost flags are active high and held low while invalid
  wire [OW:0] countExt = (OW+1)'(count);
  wire lowCount = countExt <= {1'b0, emptyOfs_r};
  wire highCount = (countExt + {1'b0, fullOfs_r}) >= DEPTH_EXT;
  always_ff @(posedge mclk)
  begin
    if (hardRst || softRst)
    begin
      almostEmptyFlag <= 1'b0;
      almostFullFlag <= 1'b0;
    end
    else
    begin
      almostEmptyFlag <= flagsEnable_r && eValid_r && lowCount;
      almostFullFlag <= flagsEnable_r && fValid_r && highCount;
    end
  end

  // Wishbone slave: one registered ack per request, one clock after it is sampled, unmapped reads return zero
  wire wbHit = wbIn.cyc && wbIn.stb && !wbOut.ack;
  // Writes land at the edge where the master sees ack, while it still holds the request
  wire wbDone = wbIn.cyc && wbIn.stb && wbOut.ack;
  wire ctrlWr = wbDone && wbIn.we && (wbIn.adr == fifo_ofs_pkg::OFS_CTRL) && wbIn.sel[0];
  wire [fifo_ofs_pkg::WB_DW-1:0] ctrlWord = (fifo_ofs_pkg::WB_DW)'(flagsEnable_r);
  wire [fifo_ofs_pkg::WB_DW-1:0] statusWord =
    ((fifo_ofs_pkg::WB_DW)'(loadSeq_r) << fifo_ofs_pkg::ST_LOADSEQ_LSB)
    | ((fifo_ofs_pkg::WB_DW)'(rdSeq_r) << fifo_ofs_pkg::ST_READSEQ_BIT)
    | ((fifo_ofs_pkg::WB_DW)'(rtState_r) << fifo_ofs_pkg::ST_RTSTATE_LSB)
    | ((fifo_ofs_pkg::WB_DW)'(eValid_r) << fifo_ofs_pkg::ST_EVALID_BIT)
    | ((fifo_ofs_pkg::WB_DW)'(fValid_r) << fifo_ofs_pkg::ST_FVALID_BIT)
    | ((fifo_ofs_pkg::WB_DW)'(fallThroughMode_r) << fifo_ofs_pkg::ST_FALL_THROUGH_MODE_BIT)
    | ((fifo_ofs_pkg::WB_DW)'(serialMode_r) << fifo_ofs_pkg::ST_SERIAL_BIT)
    | ((fifo_ofs_pkg::WB_DW)'(count) << fifo_ofs_pkg::ST_COUNT_LSB);
  wire [fifo_ofs_pkg::WB_DW-1:0] readWord =
    (wbIn.adr == fifo_ofs_pkg::OFS_CTRL) ? ctrlWord :
    (wbIn.adr == fifo_ofs_pkg::OFS_STATUS) ? statusWord :
    (wbIn.adr == fifo_ofs_pkg::OFS_EMPTY_OFS) ? emptyOfs_r :
    (wbIn.adr == fifo_ofs_pkg::OFS_FULL_OFS) ? fullOfs_r : '0;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wbOut <= '0;
      flagsEnable_r <= fifo_ofs_pkg::CTRL_FLAG_EN_RST;
      softPrs_r <= 1'b0;
    end
    else
    begin
      wbOut.ack <= wbHit;
      wbOut.dat <= (wbHit && !wbIn.we) ? readWord : '0;
      softPrs_r <= ctrlWr && wbIn.dat[fifo_ofs_pkg::CTRL_SOFT_PRS_BIT];
      if (ctrlWr)
        flagsEnable_r <= wbIn.dat[fifo_ofs_pkg::CTRL_FLAG_EN_BIT];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (hardRst);

  offsetCapture_a: assert property (
    wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_EMPTY_LO
    |=> emptyOfs_r[PW-1:0] == $past(inputBus[PW-1:0]))
    else $error("empty offset low part not captured");

  loadOrder_a: assert property (
    wrOffset |=> loadSeq_r == $past(loadSeq_r) + 2'h1)
    else $error("offset load pointer out of order");

  loadWrap_a: assert property (
    wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_FULL_HI
    |=> loadSeq_r == fifo_ofs_pkg::SEQ_EMPTY_LO)
    else $error("offset load pointer did not wrap");

  seqIndependent_a: assert property (
    wrOffset && !rdOffset |=> rdSeq_r == $past(rdSeq_r))
    else $error("read sequence moved on an offset load");

  partialKeeps_a: assert property (
    softRst |=> loadSeq_r == $past(loadSeq_r) && rdSeq_r == $past(rdSeq_r))
    else $error("partial reset moved a sequence pointer");

  memWrite_a: assert property (
    !writeEnable_n && offsetAccessSelect_n |=> loadSeq_r == $past(loadSeq_r))
    else $error("memory write advanced the load pointer");

  flagInvalid_a: assert property (
    wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_EMPTY_LO |-> ##3 !almostEmptyFlag)
    else $error("almost-empty flag shown while its offset is loading");

  flagValidDelay_a: assert property (
    wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_FULL_HI && !fDone_r
    |-> ##1 !fValid_r ##1 fValid_r)
    else $error("almost-full validity not two edges after load");

  offsetRead_a: assert property (
    rdOffset && rdSeq_r == fifo_ofs_pkg::RSEQ_EMPTY && !softRst
    |=> outputBus[OW-1:0] == $past(emptyOfs_r) && rdSeq_r == fifo_ofs_pkg::RSEQ_FULL)
    else $error("offset read order wrong");

  readResume_a: assert property (
    !rdOffset |=> rdSeq_r == $past(rdSeq_r))
    else $error("offset read pointer moved while paused");

  markEnter_a: assert property (
    markEnter && !softRst
    |=> rtState_r == fifo_ofs_pkg::RT_MARKED && markAddr_r == $past(rp_r) - (AW+1)'(1))
    else $error("mark not taken at the output word");

  rewindMove_a: assert property (
    rtState_r == fifo_ofs_pkg::RT_MARKED && mark && !rewindRequest_n && !softRst
    |=> rp_r == markAddr_r && rtState_r == fifo_ofs_pkg::RT_SETUP)
    else $error("rewind did not return to mark");

  setupStdFlag_a: assert property (
    inSetup && !fallThroughMode_r |-> !emptyFlag_n)
    else $error("empty flag high during retransmit setup");

  setupFwftFlag_a: assert property (
    inSetup && fallThroughMode_r |-> emptyFlag_n)
    else $error("output-valid low during retransmit setup");

  markGuard_a: assert property (
    markBlock && !softRst |=> wp_r == $past(wp_r))
    else $error("write pointer passed the mark");

  loadWrapCov: cover property (wrOffset && loadSeq_r == fifo_ofs_pkg::SEQ_FULL_HI);
  offsetReadCov: cover property (rdOffset ##2 rdOffset);
  rewindStdCov: cover property (inSetup && !fallThroughMode_r
    ##1 rtState_r == fifo_ofs_pkg::RT_MARKED);
  rewindFwftCov: cover property (inSetup && fallThroughMode_r ##1 !emptyFlag_n);

endmodule : fifo_offset_retransmit

// ===== sim/fifo_host_model.sv
// Host-side model that drives the FIFO write and read ports.
// Assumes one clock mclk; every signal changes by NBA just after a rising edge.
`timescale 1ns/1ps
module fifo_host_model (
  // Clock
  input wire logic mclk,
  // Write port
  output logic writeEnable_n,
  output logic offsetAccessSelect_n,
  output logic [fifo_ofs_pkg::DATA_W-1:0] inputBus,
  // Read port
  output logic readEnable_n,
  output logic mark,
  output logic rewindRequest_n
);
  initial
  begin
    writeEnable_n = 1'h1;
    offsetAccessSelect_n = 1'h1;
    inputBus = '0;
    readEnable_n = 1'h1;
    mark = 1'h0;
    rewindRequest_n = 1'h1;
  end

  // One write; back-to-back calls keep the enable low
  task automatic writeCycle(input logic memSel, input logic [71:0] d);
    @(posedge mclk);
    writeEnable_n <= 1'h0;
    offsetAccessSelect_n <= memSel;
    inputBus <= d;
  endtask : writeCycle

  // Idle data shows the inverse so stale values never look valid; select stays as it was
  task automatic writeIdle();
    @(posedge mclk);
    writeEnable_n <= 1'h1;
    inputBus <= ~inputBus;
  endtask : writeIdle

  // One read, then a disabled cycle before the next can start
  task automatic readCycle(input logic memSel);
    @(posedge mclk);
    readEnable_n <= 1'h0;
    offsetAccessSelect_n <= memSel;
    @(posedge mclk);
    readEnable_n <= 1'h1;
    offsetAccessSelect_n <= 1'h1;
    #1;
  endtask : readCycle

  task automatic markSet(input logic v);
    @(posedge mclk);
    mark <= v;
  endtask : markSet

  // Reads are already disabled when the rewind goes low
  task automatic rewind();
    @(posedge mclk);
    rewindRequest_n <= 1'h0;
    @(posedge mclk);
    rewindRequest_n <= 1'h1;
    #1;
  endtask : rewind
endmodule : fifo_host_model

// ===== sim/fifo_offset_access_and_retransmit_tb_top.sv
// Self-checking bench for offset access and retransmit from mark.
// Assumes the host model and a classic Wishbone master driven from here.
`timescale 1ns/1ps
module fifo_offset_access_and_retransmit_tb_top;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic masterReset = 1'h0;
  logic partialReset = 1'h0;
  logic fallThroughStrap = 1'h0;
  logic serialProgStrap = 1'h0;
  fifo_ofs_pkg::wbReq_t wbIn = '0;
  fifo_ofs_pkg::wbRsp_t wbOut;
  logic writeEnable_n, offsetAccessSelect_n, readEnable_n, mark, rewindRequest_n;
  logic [71:0] inputBus, outputBus;
  logic emptyFlag_n, almostEmptyFlag, almostFullFlag;
  logic [31:0] rd;
  int miscompares = 0;
  int numChecks = 0;

  always #5 mclk = ~mclk;

  fifo_offset_retransmit dut (.mclk(mclk), .sys_rst(sys_rst), .wbIn(wbIn), .wbOut(wbOut),
    .masterReset(masterReset), .partialReset(partialReset),
    .fallThroughStrap(fallThroughStrap), .serialProgStrap(serialProgStrap),
    .writeEnable_n(writeEnable_n), .offsetAccessSelect_n(offsetAccessSelect_n),
    .inputBus(inputBus), .readEnable_n(readEnable_n), .mark(mark),
    .rewindRequest_n(rewindRequest_n), .outputBus(outputBus), .emptyFlag_n(emptyFlag_n),
    .almostEmptyFlag(almostEmptyFlag), .almostFullFlag(almostFullFlag));

  fifo_host_model host (.mclk(mclk), .writeEnable_n(writeEnable_n),
    .offsetAccessSelect_n(offsetAccessSelect_n), .inputBus(inputBus),
    .readEnable_n(readEnable_n), .mark(mark), .rewindRequest_n(rewindRequest_n));

  task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
    numChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
      output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge mclk);
    wbIn <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: wd};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wbOut.ack !== 1'h1 && n < 50);
    if (n >= 50)
      chk("bus ack", 72'h1, 72'h0);
    rdat = wbOut.dat;
    wbIn <= '0;
  endtask : wbXfer

  task automatic regChk(input string nm, input logic [3:0] adr, input logic [31:0] msk,
      input logic [31:0] exp);
    logic [31:0] v;
    wbXfer(1'h0, adr, 32'h0, v);
    chk(nm, {40'h0, exp}, {40'h0, v & msk});
  endtask : regChk

  task automatic checkReset();
    regChk("seqs", fifo_ofs_pkg::OFS_STATUS, 32'h307, 32'h0);
    regChk("empty ofs", fifo_ofs_pkg::OFS_EMPTY_OFS, '1, fifo_ofs_pkg::EMPTY_OFS_RST);
    regChk("full ofs", fifo_ofs_pkg::OFS_FULL_OFS, '1, fifo_ofs_pkg::FULL_OFS_RST);
    regChk("unmapped", 4'h6, '1, 32'h0);
    wbXfer(1'h1, fifo_ofs_pkg::OFS_CTRL, 32'h1, rd);
    regChk("ctrl", fifo_ofs_pkg::OFS_CTRL, 32'h3, 32'h1);
  endtask : checkReset

  task automatic checkOffsetLoad();
    host.writeCycle(1'h0, 72'hFF_FFFF_FFFF_FFFF_1111);
    host.writeCycle(1'h0, 72'h2222);
    host.writeCycle(1'h1, 72'hAB);
    host.writeCycle(1'h0, 72'h3333);
    host.writeIdle();
    host.writeCycle(1'h0, 72'h4444);
    host.writeIdle();
    host.writeCycle(1'h0, 72'h5555);
    host.writeIdle();
    regChk("empty ofs", fifo_ofs_pkg::OFS_EMPTY_OFS, '1, 32'h2222_5555);
    regChk("full ofs", fifo_ofs_pkg::OFS_FULL_OFS, '1, 32'h4444_3333);
    regChk("count seq", fifo_ofs_pkg::OFS_STATUS, 32'h7F_0007, 32'h1_0001);
    @(posedge mclk);
    partialReset <= 1'h1;
    repeat (2) @(posedge mclk);
    partialReset <= 1'h0;
    regChk("seq kept", fifo_ofs_pkg::OFS_STATUS, 32'h7F_0007, 32'h1);
    chk("ae invalid", 72'h0, almostEmptyFlag);
    chk("af valid", 72'h1, almostFullFlag);
  endtask : checkOffsetLoad

  task automatic checkOffsetRead();
    host.readCycle(1'h0);
    chk("ofs read 1", 72'h2222_5555, outputBus);
    repeat (3) @(posedge mclk);
    host.readCycle(1'h0);
    chk("ofs read 2", 72'h4444_3333, outputBus);
    host.readCycle(1'h0);
    chk("ofs wrap", 72'h2222_5555, outputBus);
    regChk("seq indep", fifo_ofs_pkg::OFS_STATUS, 32'h7, 32'h5);
  endtask : checkOffsetRead

  // Completing the empty offset makes almost-empty valid two edges later
  task automatic checkFlags();
    host.writeCycle(1'h0, 72'h6666);
    host.writeIdle();
    #1;
    chk("ae edge 0", 72'h0, almostEmptyFlag);
    @(posedge mclk);
    #1;
    chk("ae edge 1", 72'h0, almostEmptyFlag);
    @(posedge mclk);
    #1;
    chk("ae edge 2", 72'h1, almostEmptyFlag);
    wbXfer(1'h1, fifo_ofs_pkg::OFS_CTRL, 32'h0, rd);
    @(posedge mclk);
    #1;
    chk("ae disabled", 72'h0, almostEmptyFlag);
    wbXfer(1'h1, fifo_ofs_pkg::OFS_CTRL, 32'h1, rd);
  endtask : checkFlags

  // Eight words keep well over 32 bytes between the pointers at the mark
  task automatic fill(input logic [71:0] base);
    for (int i = 0; i < 8; i++)
      host.writeCycle(1'h1, base + 72'(i));
    host.writeIdle();
    repeat (4) @(posedge mclk);
    #1;
  endtask : fill

  task automatic checkRetransmitStd();
    fill(72'h100);
    host.readCycle(1'h1);
    host.readCycle(1'h1);
    chk("std word", 72'h101, outputBus);
    host.markSet(1'h1);
    host.readCycle(1'h1);
    host.readCycle(1'h1);
    chk("std word", 72'h103, outputBus);
    regChk("marked", fifo_ofs_pkg::OFS_STATUS, 32'h38, 32'h10);
    host.rewind();
    chk("std setup", 72'h0, emptyFlag_n);
    @(posedge mclk);
    #1;
    chk("std ready", 72'h1, emptyFlag_n);
    host.readCycle(1'h1);
    chk("std marked", 72'h101, outputBus);
    host.readCycle(1'h0);
    chk("ofs over word", 72'h4444_3333, outputBus);
    wbXfer(1'h1, fifo_ofs_pkg::OFS_CTRL, 32'h3, rd);
    regChk("soft prs", fifo_ofs_pkg::OFS_STATUS, 32'h7F_003F, 32'h0A);
  endtask : checkRetransmitStd

  task automatic checkRetransmitFwft();
    host.markSet(1'h0);
    fallThroughStrap <= 1'h1;
    serialProgStrap <= 1'h1;
    masterReset <= 1'h1;
    repeat (2) @(posedge mclk);
    masterReset <= 1'h0;
    serialProgStrap <= 1'h0;
    host.writeCycle(1'h0, 72'h9999);
    host.writeIdle();
    regChk("fall_through_mode seqs", fifo_ofs_pkg::OFS_STATUS, 32'h307, 32'h300);
    regChk("serial keeps", fifo_ofs_pkg::OFS_EMPTY_OFS, '1, fifo_ofs_pkg::EMPTY_OFS_RST);
    host.readCycle(1'h0);
    chk("serial ofs read", {40'h0, fifo_ofs_pkg::EMPTY_OFS_RST}, outputBus);
    fill(72'h200);
    chk("fall_through_mode valid", 72'h0, emptyFlag_n);
    chk("fall_through_mode first", 72'h200, outputBus);
    host.markSet(1'h1);
    host.readCycle(1'h1);
    chk("fall_through_mode next", 72'h201, outputBus);
    host.rewind();
    chk("fall_through_mode setup", 72'h1, emptyFlag_n);
    @(posedge mclk);
    #1;
    chk("fall_through_mode reload flag", 72'h0, emptyFlag_n);
    chk("fall_through_mode reload", 72'h200, outputBus);
    host.readCycle(1'h1);
    chk("fall_through_mode after", 72'h201, outputBus);
  endtask : checkRetransmitFwft

  task automatic final_report();
    if (miscompares == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial
  begin
    #100us;
    miscompares++;
    final_report();
  end

  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'h0;
    checkReset();
    checkOffsetLoad();
    checkOffsetRead();
    checkFlags();
    checkRetransmitStd();
    checkRetransmitFwft();
    final_report();
  end
endmodule : fifo_offset_access_and_retransmit_tb_top
